// >>> common/ctts_pkg.sv
/*
  Constants shared by the cascaded timer block: widths, reset values,
  count-source encodings and the fixed ratios.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ctts_pkg;
  localparam int PSC_W = 8;
  localparam int TMR_W = 8;
  localparam int T5_W = 16;
  localparam int WDT_W = 16;
  localparam int PIN_N = 6;
  localparam int IRQ_N = 5;
  // Fixed dividers
  localparam int T5_BASE_RATIO = 8192;
  localparam int WDT_RATIO = 65534;
  // Synchroniser pin indices
  localparam int PIN_MAIN_OSC = 0;
  localparam int PIN_SUB_OSC = 1;
  localparam int PIN_CNT0 = 2;
  localparam int PIN_CNT1 = 3;
  localparam int PIN_IRQ0 = 4;
  localparam int PIN_IRQ1 = 5;
  // Timer 1 count sources
  localparam logic [1:0] T1_SRC_INSTR = 2'h0;
  localparam logic [1:0] T1_SRC_PSC = 2'h1;
  localparam logic [1:0] T1_SRC_T5 = 2'h2;
  localparam logic [1:0] T1_SRC_PIN = 2'h3;
  // Timer 2 count sources
  localparam logic [1:0] T2_SRC_SYS = 2'h0;
  localparam logic [1:0] T2_SRC_PSC = 2'h1;
  localparam logic [1:0] T2_SRC_T1 = 2'h2;
  localparam logic [1:0] T2_SRC_PWM = 2'h3;
  // Timer 3 count sources
  localparam logic [1:0] T3_SRC_PWM = 2'h0;
  localparam logic [1:0] T3_SRC_PSC = 2'h1;
  localparam logic [1:0] T3_SRC_T2 = 2'h2;
  localparam logic [1:0] T3_SRC_PIN = 2'h3;
  // Timer 4 count sources
  localparam logic T4_SRC_OSC = 1'h0;
  localparam logic T4_SRC_PSC = 1'h1;
  // Reset values
  localparam logic [TMR_W-1:0] TMR_RST = 8'h00;
  localparam logic [T5_W-1:0] T5_RST = 16'h0000;
  localparam logic [IRQ_N-1:0] IRQ_RST = 5'h00;
endpackage

// >>> common/ctts_cnt_if.sv
/*
  Control and status bundle between the timer top and one down counter.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
interface ctts_cnt_if #(parameter int W = 8);
  logic run;
  logic load;
  logic tick;
  logic [W-1:0] reload;
  logic [W-1:0] value;
  logic underflow;
  modport ctl (output run, output load, output tick, output reload, input value, input underflow);
  modport cnt (input run, input load, input tick, input reload, output value, output underflow);
endinterface
`default_nettype wire

// >>> logic/ctts_dcnt.sv
/*
  Auto-reload binary down counter: divides its tick by reload+1.
  Assumes tick is a one-cycle enable on mclk and load is pulsed on start.
*/
`timescale 1ns/10ps
`default_nettype none
module ctts_dcnt
  import ctts_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  ctts_cnt_if.cnt bus
);
  if (W < 2) begin : g_chk
    $error("ctts_dcnt width too small");
  end

  logic [W-1:0] value_ff;
  logic [W-1:0] nxt_value;
  logic uf_ff;
  wire hit = bus.run & bus.tick & ~bus.load;
  wire at_zero = (value_ff == '0);
  wire nxt_uf = hit & at_zero;

  // Reload on underflow and keep counting; stop retains state
  assign nxt_value = bus.load ? bus.reload : (hit ? (at_zero ? bus.reload : value_ff - 1'b1) : value_ff); // see RQ10

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      value_ff <= '0;
      uf_ff <= 1'b0;
    end else begin
      value_ff <= nxt_value;
      uf_ff <= nxt_uf;
    end
  end

  assign bus.value = value_ff;
  assign bus.underflow = uf_ff;

  ////////////////////////////////////////////////////////////////////////
  a_reload_on_uf: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ10
    hit && at_zero |=> bus.underflow && (bus.value == $past(bus.reload)))
    else $error("counter did not reload on underflow");
  a_hold_when_stopped: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ1
    !bus.run && !bus.load |=> $stable(bus.value) && !bus.underflow)
    else $error("stopped counter moved");
  a_uf_from_zero: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ3
    bus.underflow |-> $past(bus.value) == '0 && $past(bus.tick))
    else $error("underflow without zero count");
endmodule // ctts_dcnt
`default_nettype wire

// >>> logic/ctts_timers.sv
/*
  Cascaded timer block: prescaler, timers 1 to 4, fixed divider 5, watchdog.
  Assumes instruction and system clock enables come from mclk logic;
  oscillator and pin inputs are asynchronous.
*/
// How it works
// RQ1 - Eight-bit prescaler divides instruction clock 1..256
// RQ2 - Prescaler pulse feeds timers 1-4
// RQ3 - Timer 1 divides 1..256, irq0-linked, interrupts
// RQ4 - Timer 1 underflow feeds timer 2, pin 0
// RQ5 - Timer 2 four sources, feeds timer 3, interrupts
// RQ6 - Timer 3 four sources, irq1-linked, interrupts
// RQ7 - Timer 4 oscillator/prescaler, PWM, pin 1, interrupts
// RQ8 - Timer 5 subclock divider 8192..65536, interrupts
// RQ9 - Watchdog 65534 flags, resets on second pass
// RQ10 - Underflow sets flag, reloads, keeps counting
// RQ11 - Timer 1 sources: instr, prescaler, timer5, pin
// RQ12 - Async inputs synchronised, edge-detected before counting
// RQ13 - Interrupt flags sticky; new underflow beats clear
`timescale 1ns/10ps
`default_nettype none
module ctts_timers
  import ctts_pkg::*;
#(
  parameter int WDT_COUNT = WDT_RATIO,
  parameter int T5_BASE = T5_BASE_RATIO
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instruction_cycle_clock,
  input wire logic system_base_clock,
  input wire logic main_osc_input,
  input wire logic sub_osc_input,
  input wire logic ext_irq_pin_0,
  input wire logic ext_irq_pin_1,
  input wire logic counter_pin_0_in,
  input wire logic counter_pin_1_in,
  input wire logic psc_run,
  input wire logic [PSC_W-1:0] psc_reload,
  input wire logic t1_run,
  input wire logic [1:0] t1_src,
  input wire logic t1_link,
  input wire logic [TMR_W-1:0] t1_reload,
  input wire logic t2_run,
  input wire logic [1:0] t2_src,
  input wire logic [TMR_W-1:0] t2_reload,
  input wire logic t3_run,
  input wire logic [1:0] t3_src,
  input wire logic t3_link,
  input wire logic [TMR_W-1:0] t3_reload,
  input wire logic t4_run,
  input wire logic t4_src,
  input wire logic [TMR_W-1:0] t4_reload,
  input wire logic t5_run,
  input wire logic [1:0] t5_ratio,
  input wire logic cnt0_out_sel,
  input wire logic cnt0_out_en,
  input wire logic cnt1_out_en,
  input wire logic wdt_restart,
  input wire logic [IRQ_N-1:0] irq_clr,
  output logic prescaler_out_pulse,
  output logic timer1_underflow,
  output logic timer2_underflow,
  output logic timer5_underflow,
  output logic pulse_width_output,
  output logic [IRQ_N-1:0] timer_irq_flags,
  output logic watchdog_flag,
  output logic system_reset_req,
  output logic counter_pin_0_out,
  output logic counter_pin_0_oe,
  output logic counter_pin_1_out,
  output logic counter_pin_1_oe
);
  if (WDT_COUNT < 2 || WDT_COUNT > 65536 || T5_BASE < 2 || T5_BASE > 8192) begin : g_chk
    $error("ctts_timers count parameter out of range");
  end

  localparam logic [WDT_W-1:0] WDT_TOP = WDT_W'(WDT_COUNT - 1);

  function automatic logic [T5_W-1:0] t5_top(input logic [1:0] ratio);
    logic [T5_W:0] full;
    full = (T5_W+1)'(T5_BASE) << ratio;
    return T5_W'(full - 1'b1);
  endfunction

  function automatic logic rise(input logic now, input logic was);
    return now & ~was;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; glitch filter only trusts stages two and three
  logic [PIN_N-1:0] s1_ff, s2_ff, s3_ff, filt_ff, filt_d_ff;
  logic [PIN_N-1:0] nxt_filt;
  wire [PIN_N-1:0] pins = {ext_irq_pin_1, ext_irq_pin_0, counter_pin_1_in, counter_pin_0_in,
                           sub_osc_input, main_osc_input};
  assign nxt_filt = (s2_ff ~^ s3_ff) & s3_ff | (s2_ff ^ s3_ff) & filt_ff; // see RQ12
  wire [PIN_N-1:0] pin_edge = filt_ff & ~filt_d_ff; // see RQ12

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      filt_ff <= '0;
      filt_d_ff <= '0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
      filt_d_ff <= filt_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter bundles
  ctts_cnt_if #(.W(PSC_W)) psc_if ();
  ctts_cnt_if #(.W(TMR_W)) t1_if ();
  ctts_cnt_if #(.W(TMR_W)) t2_if ();
  ctts_cnt_if #(.W(TMR_W)) t3_if ();
  ctts_cnt_if #(.W(TMR_W)) t4_if ();
  ctts_cnt_if #(.W(T5_W)) t5_if ();

  logic [5:0] run_d_ff;
  logic t1_go_ff, t3_go_ff, psc_half_ff, pwm_ff, pwm_d_ff;
  wire [5:0] run_now = {t5_run, t4_run, t3_run, t2_run, t1_run, psc_run};
  wire [5:0] start = run_now & ~run_d_ff;
  wire psc_uf = psc_if.underflow;
  wire pwm_edge = rise(pwm_ff, pwm_d_ff);

  // Source selectors
  wire t1_sel_tick = (t1_src == T1_SRC_INSTR) ? instruction_cycle_clock : // see RQ11
                     (t1_src == T1_SRC_PSC) ? psc_uf :
                     (t1_src == T1_SRC_T5) ? t5_if.underflow : pin_edge[PIN_CNT0];
  wire t2_sel_tick = (t2_src == T2_SRC_SYS) ? system_base_clock : // see RQ5
                     (t2_src == T2_SRC_PSC) ? psc_uf :
                     (t2_src == T2_SRC_T1) ? t1_if.underflow : pwm_edge;
  wire t3_sel_tick = (t3_src == T3_SRC_PWM) ? pwm_edge : // see RQ6
                     (t3_src == T3_SRC_PSC) ? psc_uf :
                     (t3_src == T3_SRC_T2) ? t2_if.underflow : pin_edge[PIN_CNT1];
  // Prescaler reaches timer 4 halved
  wire t4_sel_tick = (t4_src == T4_SRC_OSC) ? pin_edge[PIN_MAIN_OSC] : (psc_uf & psc_half_ff); // see RQ7
  // Linked timers wait for the external interrupt edge before counting
  wire t1_gate = ~t1_link | t1_go_ff; // see RQ3
  wire t3_gate = ~t3_link | t3_go_ff; // see RQ6

  assign psc_if.run = psc_run;
  assign psc_if.load = start[0];
  assign psc_if.tick = instruction_cycle_clock; // see RQ1
  assign psc_if.reload = psc_reload;
  assign t1_if.run = t1_run;
  assign t1_if.load = start[1];
  assign t1_if.tick = t1_sel_tick & t1_gate;
  assign t1_if.reload = t1_reload;
  assign t2_if.run = t2_run;
  assign t2_if.load = start[2];
  assign t2_if.tick = t2_sel_tick;
  assign t2_if.reload = t2_reload;
  assign t3_if.run = t3_run;
  assign t3_if.load = start[3];
  assign t3_if.tick = t3_sel_tick & t3_gate;
  assign t3_if.reload = t3_reload;
  assign t4_if.run = t4_run;
  assign t4_if.load = start[4];
  assign t4_if.tick = t4_sel_tick;
  assign t4_if.reload = t4_reload;
  assign t5_if.run = t5_run;
  assign t5_if.load = start[5];
  assign t5_if.tick = pin_edge[PIN_SUB_OSC]; // see RQ8
  assign t5_if.reload = t5_top(t5_ratio); // see RQ8

  ctts_dcnt #(.W(PSC_W)) u_psc (.mclk(mclk), .rst_n(rst_n), .bus(psc_if));
  ctts_dcnt #(.W(TMR_W)) u_t1 (.mclk(mclk), .rst_n(rst_n), .bus(t1_if));
  ctts_dcnt #(.W(TMR_W)) u_t2 (.mclk(mclk), .rst_n(rst_n), .bus(t2_if));
  ctts_dcnt #(.W(TMR_W)) u_t3 (.mclk(mclk), .rst_n(rst_n), .bus(t3_if));
  ctts_dcnt #(.W(TMR_W)) u_t4 (.mclk(mclk), .rst_n(rst_n), .bus(t4_if));
  ctts_dcnt #(.W(T5_W)) u_t5 (.mclk(mclk), .rst_n(rst_n), .bus(t5_if));

  assign prescaler_out_pulse = psc_if.underflow; // see RQ2
  assign timer1_underflow = t1_if.underflow; // see RQ4
  assign timer2_underflow = t2_if.underflow;
  assign timer5_underflow = t5_if.underflow;
  assign pulse_width_output = pwm_ff;

  ////////////////////////////////////////////////////////////////////////
  // Link gates, PWM, pin outputs and interrupt flags
  logic [IRQ_N-1:0] irq_ff;
  logic cnt0_tgl_ff, cnt0_oe_ff, cnt1_out_ff, cnt1_oe_ff;
  wire [IRQ_N-1:0] uf_vec = {t5_if.underflow, t4_if.underflow, t3_if.underflow,
                             t2_if.underflow, t1_if.underflow};
  // Set beats a simultaneous clear so no underflow is lost
  wire [IRQ_N-1:0] nxt_irq = (irq_ff & ~irq_clr) | uf_vec; // see RQ13
  wire nxt_t1_go = t1_run & (t1_go_ff | pin_edge[PIN_IRQ0]); // see RQ3
  wire nxt_t3_go = t3_run & (t3_go_ff | pin_edge[PIN_IRQ1]); // see RQ6
  wire nxt_pwm = t4_run & (pwm_ff ^ t4_if.underflow); // see RQ7
  wire cnt0_uf = cnt0_out_sel ? t2_if.underflow : t1_if.underflow;
  wire nxt_cnt0_tgl = cnt0_tgl_ff ^ cnt0_uf; // see RQ4

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_d_ff <= '0;
      t1_go_ff <= 1'b0;
      t3_go_ff <= 1'b0;
      psc_half_ff <= 1'b0;
      pwm_ff <= 1'b0;
      pwm_d_ff <= 1'b0;
      irq_ff <= IRQ_RST;
      cnt0_tgl_ff <= 1'b0;
      cnt0_oe_ff <= 1'b0;
      cnt1_out_ff <= 1'b0;
      cnt1_oe_ff <= 1'b0;
    end else begin
      run_d_ff <= run_now;
      t1_go_ff <= nxt_t1_go;
      t3_go_ff <= nxt_t3_go;
      psc_half_ff <= psc_half_ff ^ psc_uf;
      pwm_ff <= nxt_pwm;
      pwm_d_ff <= pwm_ff;
      irq_ff <= nxt_irq; // see RQ10
      cnt0_tgl_ff <= nxt_cnt0_tgl;
      cnt0_oe_ff <= cnt0_out_en & (t1_src != T1_SRC_PIN);
      cnt1_out_ff <= nxt_pwm; // see RQ7
      cnt1_oe_ff <= cnt1_out_en & (t3_src != T3_SRC_PIN);
    end
  end

  assign timer_irq_flags = irq_ff;
  assign counter_pin_0_out = cnt0_tgl_ff;
  assign counter_pin_0_oe = cnt0_oe_ff;
  assign counter_pin_1_out = cnt1_out_ff;
  assign counter_pin_1_oe = cnt1_oe_ff;

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: free running; a second wrap with the flag still up resets
  logic [WDT_W-1:0] wdt_ff;
  logic wdf_ff, rst_req_ff;
  wire wdt_wrap = instruction_cycle_clock & (wdt_ff == '0);
  wire [WDT_W-1:0] nxt_wdt = ~instruction_cycle_clock ? wdt_ff : (wdt_wrap ? WDT_TOP : wdt_ff - 1'b1); // see RQ9
  wire nxt_wdf = (wdf_ff & ~wdt_restart) | wdt_wrap; // see RQ9
  wire nxt_rst_req = wdt_wrap & wdf_ff & ~wdt_restart; // see RQ9

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wdt_ff <= WDT_TOP;
      wdf_ff <= 1'b0;
      rst_req_ff <= 1'b0;
    end else begin
      wdt_ff <= nxt_wdt;
      wdf_ff <= nxt_wdf;
      rst_req_ff <= nxt_rst_req;
    end
  end

  assign watchdog_flag = wdf_ff;
  assign system_reset_req = rst_req_ff;

  ////////////////////////////////////////////////////////////////////////
  a_irq_set_wins: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ13
    uf_vec[0] |=> timer_irq_flags[0])
    else $error("timer 1 flag lost on clear");
  a_irq_sticky: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ13
    timer_irq_flags[2] && !irq_clr[2] |=> timer_irq_flags[2])
    else $error("timer 3 flag dropped without clear");
  a_wdt_second_pass: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ9
    wdt_wrap && watchdog_flag && !wdt_restart |=> system_reset_req && watchdog_flag)
    else $error("watchdog did not reset on second pass");
  a_wdt_no_early: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ9
    system_reset_req |-> $past(wdt_ff) == '0 && $past(watchdog_flag))
    else $error("spurious watchdog reset");
  a_t1_link_wait: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ3
    t1_run && t1_link && !t1_go_ff && !start[1] |=> $stable(t1_if.value))
    else $error("linked timer 1 counted before irq edge");
  a_pin_edge_sync: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ12
    pin_edge[PIN_CNT0] |-> $past(s3_ff[PIN_CNT0]) && $past(s2_ff[PIN_CNT0]))
    else $error("pin edge without agreed stages");
  a_cnt0_toggle: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ4
    !cnt0_out_sel && t1_if.underflow |=> counter_pin_0_out != $past(counter_pin_0_out))
    else $error("pin 0 did not toggle on timer 1 underflow");
  a_pwm_toggle: assert property (@(posedge mclk) disable iff (!rst_n) // see RQ7
    t4_run && t4_if.underflow |=> pulse_width_output != $past(pulse_width_output))
    else $error("pwm did not toggle on timer 4 underflow");
endmodule // ctts_timers
`default_nettype wire

// >>> testbench/ctts_far_model.sv
/*
  Far-side model: the clock enables and the two oscillator inputs.
  Assumes the block samples everything on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ctts_far_model (
  input wire logic mclk,
  input wire logic rst_n,
  output logic instruction_cycle_clock,
  output logic system_base_clock,
  output logic main_osc_input,
  output logic sub_osc_input
);
  logic [3:0] phase_ff;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_ff <= 4'h0;
    end else begin
      phase_ff <= phase_ff + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  // Enables one cycle wide; oscillators slow enough for the filter
  assign instruction_cycle_clock = rst_n & (phase_ff[1:0] == 2'h3);
  assign system_base_clock = rst_n & phase_ff[0];
  assign main_osc_input = phase_ff[2];
  assign sub_osc_input = phase_ff[2];
endmodule // ctts_far_model
`default_nettype wire

// >>> testbench/cascaded_timer_subsystem_test.sv
/*
  Self-checking bench for the cascaded timers.
  Assumes the far-side model: instruction tick every 4 cycles, oscillators rise every 8.
*/
`timescale 1ns/10ps
`default_nettype none
module cascaded_timer_subsystem_test;
  import ctts_pkg::*;
  logic mclk = 1'h0, rst_n = 1'h0, ext_irq_pin_0 = 1'h0, ext_irq_pin_1 = 1'h0, counter_pin_0_in = 1'h0;
  logic counter_pin_1_in = 1'h0, cnt0_out_sel = 1'h0;
  logic psc_run = 1'h0, t1_run = 1'h0, t1_link = 1'h0, t2_run = 1'h0, t3_run = 1'h0, t3_link = 1'h0;
  logic t4_run = 1'h0, t4_src = 1'h0, t5_run = 1'h0, cnt0_out_en = 1'h0, cnt1_out_en = 1'h0, wdt_restart = 1'h0;
  logic [1:0] t1_src = 2'h0, t2_src = 2'h0, t3_src = 2'h0, t5_ratio = 2'h0;
  logic [7:0] psc_reload = 8'h03, t1_reload = 8'h00, t2_reload = 8'h00, t3_reload = 8'h00, t4_reload = 8'h00;
  logic [4:0] irq_clr = 5'h00, timer_irq_flags;
  logic instruction_cycle_clock, system_base_clock, main_osc_input, sub_osc_input;
  logic prescaler_out_pulse, timer1_underflow, timer2_underflow, timer5_underflow, pulse_width_output;
  logic watchdog_flag, system_reset_req, counter_pin_0_out, counter_pin_0_oe, counter_pin_1_out, counter_pin_1_oe;
  logic [4:0] pulses;
  int failures = 0;
  int checks = 0;
  assign pulses = {system_reset_req, timer5_underflow, timer2_underflow, timer1_underflow, prescaler_out_pulse};
  initial begin
    forever #5 mclk = ~mclk;
  end
  ctts_far_model i_far (.mclk, .rst_n, .instruction_cycle_clock, .system_base_clock, .main_osc_input, .sub_osc_input);
  // Short watchdog and divider keep the run brief
  ctts_timers #(.WDT_COUNT(6), .T5_BASE(4)) i_dut (.mclk, .rst_n, .instruction_cycle_clock, .system_base_clock,
    .main_osc_input, .sub_osc_input, .ext_irq_pin_0, .ext_irq_pin_1, .counter_pin_0_in,
    .counter_pin_1_in, .psc_run, .psc_reload, .t1_run, .t1_src, .t1_link, .t1_reload, .t2_run, .t2_src,
    .t2_reload, .t3_run, .t3_src, .t3_link, .t3_reload, .t4_run, .t4_src, .t4_reload, .t5_run, .t5_ratio,
    .cnt0_out_sel, .cnt0_out_en, .cnt1_out_en, .wdt_restart, .irq_clr, .prescaler_out_pulse,
    .timer1_underflow, .timer2_underflow, .timer5_underflow, .pulse_width_output, .timer_irq_flags,
    .watchdog_flag, .system_reset_req, .counter_pin_0_out, .counter_pin_0_oe, .counter_pin_1_out,
    .counter_pin_1_oe);
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // Bounded wait; n returns the cycles spent
  task automatic wait_pulse(input int idx, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (pulses[idx] !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      failures++;
      $display("unexpected at %0t: no pulse on %0d", $time, idx);
      summarize();
    end
  endtask
  // First two gaps skipped: they may belong to the old setting
  task automatic period(input int idx, input int exp);
    int n;
    wait_pulse(idx, n);
    wait_pulse(idx, n);
    wait_pulse(idx, n);
    check(n, exp, "pulse period");
  endtask
  task automatic count_pulses(input int idx, input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(negedge mclk);
      n += (pulses[idx] !== 1'b0);
    end
  endtask
  task automatic pin_toggle(input int k);
    repeat (k) begin
      @(posedge mclk) counter_pin_0_in <= 1'h1;
      counter_pin_1_in <= 1'h1;
      repeat (6) @(posedge mclk);
      counter_pin_0_in <= 1'h0;
      counter_pin_1_in <= 1'h0;
      repeat (5) @(posedge mclk);
    end
  endtask
  task automatic start_t1(input logic [1:0] src, input logic [7:0] rl);
    @(posedge mclk) t1_run <= 1'h0;
    t1_src <= src;
    t1_reload <= rl;
    @(posedge mclk) t1_run <= 1'h1;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_prescaler();
    logic [7:0] rl [3] = '{8'hFF, 8'h00, 8'h03};
    foreach (rl[i]) begin
      @(posedge mclk) psc_run <= 1'h0;
      psc_reload <= rl[i];
      @(posedge mclk) psc_run <= 1'h1;
      period(0, 4 * (rl[i] + 1));
    end
    $display("test prescaler done");
  endtask
  task automatic t_timer1();
    logic a;
    int n;
    @(posedge mclk) cnt0_out_en <= 1'h1;
    t5_run <= 1'h1;
    start_t1(T1_SRC_INSTR, 8'h02);
    period(1, 12);
    @(negedge mclk) check(timer_irq_flags[0], 1, "timer 1 flag");
    a = counter_pin_0_out;
    wait_pulse(1, n);
    repeat (2) @(negedge mclk);
    check(counter_pin_0_out, {~a}, "pin 0 toggle");
    check(counter_pin_0_oe, 1, "pin 0 drive");
    start_t1(T1_SRC_PSC, 8'h01);
    period(1, 32);
    start_t1(T1_SRC_T5, 8'h00);
    period(1, 32);
    @(posedge mclk) t1_run <= 1'h0;
    repeat (20) @(posedge mclk);
    @(negedge mclk) check(timer_irq_flags[0], 1, "flag held");
    @(posedge mclk) irq_clr <= 5'h01;
    @(posedge mclk) irq_clr <= 5'h00;
    @(negedge mclk) check(timer_irq_flags[0], 0, "flag cleared");
    $display("test timer 1 done");
  endtask
  task automatic t_timer2();
    logic [1:0] src [2] = '{T2_SRC_T1, T2_SRC_SYS};
    int rl [2] = '{1, 4};
    int ex [2] = '{24, 10};
    start_t1(T1_SRC_INSTR, 8'h02);
    foreach (src[i]) begin
      @(posedge mclk) t2_run <= 1'h0;
      t2_src <= src[i];
      t2_reload <= 8'(rl[i]);
      @(posedge mclk) t2_run <= 1'h1;
      period(2, ex[i]);
    end
    @(negedge mclk) check(timer_irq_flags[1], 1, "timer 2 flag");
    $display("test timer 2 done");
  endtask
  task automatic t_timer5();
    for (int r = 0; r < 2; r++) begin
      @(posedge mclk) t5_ratio <= 2'(r);
      period(3, 32 << r);
    end
    @(negedge mclk) check(timer_irq_flags[4], 1, "timer 5 flag");
    $display("test timer 5 done");
  endtask
  task automatic t_pin();
    int n;
    start_t1(T1_SRC_PIN, 8'h00);
    fork
      pin_toggle(3);
      count_pulses(1, 50, n);
    join
    check(n, 3, "pin edges counted");
    @(posedge mclk) t1_link <= 1'h1;
    start_t1(T1_SRC_PIN, 8'h00);
    fork
      pin_toggle(3);
      count_pulses(1, 50, n);
    join
    check(n, 0, "linked, not started");
    @(posedge mclk) ext_irq_pin_0 <= 1'h1;
    repeat (8) @(posedge mclk);
    fork
      pin_toggle(2);
      count_pulses(1, 50, n);
    join
    check(n, 2, "linked, started");
    $display("test pin count done");
  endtask
  task automatic t_chain();
    int n;
    int m;
    @(posedge mclk) t4_run <= 1'h1;
    t3_src <= T3_SRC_PWM;
    t3_link <= 1'h1;
    cnt1_out_en <= 1'h1;
    @(posedge mclk) t3_run <= 1'h1;
    repeat (100) @(negedge mclk);
    check(timer_irq_flags[2], 0, "timer 3 waits for link");
    check(timer_irq_flags[3], 1, "timer 4 flag");
    check(counter_pin_1_oe, 1, "pin 1 drive");
    n = 0;
    m = 0;
    // Two whole pwm periods, so the phase does not matter
    repeat (32) begin
      @(negedge mclk);
      n += (pulse_width_output !== 1'b0);
      m += (counter_pin_1_out !== 1'b0);
    end
    check(n, 16, "pwm duty");
    check(m, 16, "pin 1 wave");
    @(posedge mclk) ext_irq_pin_1 <= 1'h1;
    repeat (100) @(negedge mclk);
    check(timer_irq_flags[2], 1, "timer 3 from pwm");
    $display("test chain done");
  endtask
  task automatic t_sources();
    int n;
    @(posedge mclk) t3_src <= T3_SRC_PIN;
    // Let any pwm tick still in flight land before clearing
    repeat (3) @(posedge mclk);
    irq_clr <= 5'h04;
    @(posedge mclk) irq_clr <= 5'h00;
    repeat (2) @(negedge mclk);
    check(timer_irq_flags[2], 0, "timer 3 cleared");
    check(counter_pin_1_oe, 0, "pin 1 released");
    pin_toggle(1);
    @(negedge mclk) check(timer_irq_flags[2], 1, "timer 3 from pin");
    @(posedge mclk) t4_src <= T4_SRC_PSC;
    t2_src <= T2_SRC_PWM;
    t2_reload <= 8'h00;
    cnt0_out_sel <= 1'h1;
    period(2, 64);
    @(posedge mclk) t2_src <= T2_SRC_PSC;
    period(2, 16);
    n = 0;
    repeat (32) begin
      @(negedge mclk);
      n += (counter_pin_0_out !== 1'b0);
    end
    check(n, 16, "pin 0 from timer 2");
    $display("test sources done");
  endtask
  task automatic t_watchdog();
    int n;
    period(4, 24);
    @(posedge mclk) wdt_restart <= 1'h1;
    @(posedge mclk) wdt_restart <= 1'h0;
    @(negedge mclk) check(watchdog_flag, 0, "flag restarted");
    count_pulses(4, 30, n);
    check(n, 0, "single pass no reset");
    check(watchdog_flag, 1, "flag after pass");
    $display("test watchdog done");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    @(negedge mclk) check({pulses, timer_irq_flags, watchdog_flag, counter_pin_0_oe}, 0, "after reset");
    t_prescaler();
    t_timer1();
    t_timer2();
    t_timer5();
    t_pin();
    t_chain();
    t_sources();
    t_watchdog();
    summarize();
  end
endmodule // cascaded_timer_subsystem_test
`default_nettype wire
